/* File: kvm_channel_select_auth_power.sv */
// Top of the channel selection, auth power cycling and filter admin logic.
`timescale 1ns/1ns
`default_nettype none
module kvm_channel_select_auth_power
  import kvm_sel_pkg::*;
#(
  parameter int          CH_W    = 2,
  parameter int unsigned OFF_CYC = AUTH_OFF_CYC
) (
  // Clock and reset.
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // Selection controls from pins.
  input  wire logic            mech_remote_i,
  input  wire logic            btn_req_i,
  input  wire logic [CH_W-1:0] btn_chan_i,
  input  wire logic            rmt_req_i,
  input  wire logic [CH_W-1:0] rmt_chan_i,
  // Keyboard shortcut request, never acted upon.
  input  wire logic            kbd_hotkey_i,
  // Peripheral identity from the qualification logic.
  input  wire logic            kbd_is_kbd_i,
  input  wire logic            mouse_is_mouse_i,
  input  wire logic            auth_emulated_i,
  // Administration.
  input  wire logic            admin_login_i,
  input  wire logic            admin_logout_i,
  input  wire logic            filt_wr_i,
  input  wire logic [7:0]      filt_data_i,
  // Outputs.
  output logic [CH_W-1:0]      led_chan_o,
  output logic [CH_W-1:0]      kbd_route_o,
  output logic [CH_W-1:0]      mouse_route_o,
  output logic                 kbd_en_o,
  output logic                 mouse_en_o,
  output logic [CH_W-1:0]      auth_route_o,
  output logic                 auth_pwr_o,
  output logic                 admin_role_o,
  output logic [7:0]           configurable_device_filtering_o,
  output logic                 filt_reject_o
);
  // Pin synchronisers: first stage read only by the second.
  localparam int SW = 6 + 2 * CH_W;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {mech_remote_i, btn_req_i, rmt_req_i, admin_login_i, admin_logout_i,
                filt_wr_i, btn_chan_i, rmt_chan_i};
      sync2 <= sync1;
    end
  end

  // Synchronised request edges for one-shot acceptance.
  logic btn_q;
  logic rmt_q;
  logic btn_rise;
  logic rmt_rise;
  logic wr_q;
  assign btn_rise = sync2[SW-2] & ~btn_q;
  assign rmt_rise = sync2[SW-3] & ~rmt_q;

  // Qualified request carrier.
  sel_req_if #(.CH_W(CH_W)) req ();

  kvm_req_arbiter #(.CH_W(CH_W)) u_arb (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .mech_sel (sync2[SW-1]),
    .btn_req  (btn_rise),
    .btn_chan (sync2[2*CH_W-1:CH_W]),
    .rmt_req  (rmt_rise),
    .rmt_chan (sync2[CH_W-1:0]),
    .req      (req)
  );

  // Block state apart from the pin synchronisers.
  typedef struct packed {
    logic [CH_W-1:0] chan;
    pwr_state_e      pwr;
    logic [31:0]     tmr;
    logic            admin;
    logic [7:0]      filt;
    logic            rej;
    logic            btn_q;
    logic            rmt_q;
    logic            wr_q;
  } top_s;
  top_s st;
  top_s next_st;

  assign btn_q = st.btn_q;
  assign rmt_q = st.rmt_q;
  assign wr_q  = st.wr_q;

  // Next-state logic for selection, power timer and admin functions.
  always_comb begin
    logic wr_rise;
    wr_rise = 1'b0;
    next_st = st;
    next_st.btn_q = sync2[SW-2];
    next_st.rmt_q = sync2[SW-3];
    next_st.wr_q  = sync2[SW-6];
    wr_rise = sync2[SW-6] & ~st.wr_q;
    next_st.rej = 1'b0;
    // Hotkey input is deliberately not part of any term below.
    if (req.valid && req.chan != st.chan) begin
      next_st.chan = req.chan;
      if (!auth_emulated_i) begin
        next_st.pwr = PWR_OFF;
        next_st.tmr = OFF_CYC - 1;
      end
    end else if (st.pwr == PWR_OFF) begin
      // Count out the power-off interval, then restore power.
      if (st.tmr == 32'h0000_0000) begin
        next_st.pwr = PWR_ON;
      end else begin
        next_st.tmr = st.tmr - 32'h0000_0001;
      end
    end
    // Role tracking: logout wins so the role drops safely.
    if (sync2[SW-5]) begin
      next_st.admin = 1'b0;
    end else if (sync2[SW-4]) begin
      next_st.admin = 1'b1;
    end
    // Filter list writes only under the administrator role.
    if (wr_rise) begin
      if (st.admin) begin
        next_st.filt = filt_data_i;
      end else begin
        next_st.rej = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st       <= '0;
      st.chan  <= CHAN_RESET;
      st.pwr   <= PWR_ON;
      st.filt  <= FILTER_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Indicator follows the index register from reset with no gap.
  assign led_chan_o    = st.chan;
  // Keyboard and mouse share one index.
  assign kbd_route_o   = st.chan;
  assign mouse_route_o = st.chan;
  assign kbd_en_o      = kbd_is_kbd_i & mouse_is_mouse_i;
  assign mouse_en_o    = kbd_is_kbd_i & mouse_is_mouse_i;
  // Auth path is its own output, never merged with HID paths.
  assign auth_route_o  = st.chan;
  assign auth_pwr_o    = (st.pwr == PWR_ON);
  assign admin_role_o  = st.admin;
  assign configurable_device_filtering_o = st.filt;
  assign filt_reject_o = st.rej;
endmodule
`default_nettype wire

/* File: kvm_sel_pkg.sv */
// Package with constants and types for the channel selection block.
// What this block does
// - Power-cycle auth port at least one second.
// - Auth path never shares keyboard/mouse paths.
// - Filter lists changed only by administrator.
// - Keep user and administrator roles distinct.
// - Keyboard key sequences never change channel.
// - Switch only on authorized mechanism requests.
// - Exactly one selection mechanism active.
// - Indicator always shows selected computer.
// - Keyboard and mouse always routed together.
// - Only identified keyboard/mouse get switched.
package kvm_sel_pkg;
  // Clock rate in Hz.
  localparam int unsigned CLK_HZ        = 10_000_000;
  // Least auth power-off time in milliseconds.
  localparam int unsigned AUTH_OFF_MS   = 1000;
  // Cycles for the power-off interval, with CLK_HZ/1000 truncated.
  localparam int unsigned AUTH_OFF_CYC  = (CLK_HZ / 1000) * AUTH_OFF_MS;
  // Channel index after reset.
  localparam logic [1:0]  CHAN_RESET    = 2'h0;
  // Filter list word after reset.
  localparam logic [7:0]  FILTER_RESET  = 8'h00;
  // Mechanism index after reset (front panel buttons).
  localparam logic [0:0]  MECH_RESET    = 1'h0;

  // Power sequencing states, Gray along the path.
  typedef enum logic [1:0] {
    PWR_ON  = 2'b00,
    PWR_OFF = 2'b01
  } pwr_state_e;
endpackage

/* File: sel_req_if.sv */
// Interface carrying a qualified channel request to the selection core.
`timescale 1ns/1ns
`default_nettype none
interface sel_req_if #(parameter int CH_W = 2);
  logic            valid;   // Accepted request pulse.
  logic [CH_W-1:0] chan;    // Requested channel.
  modport src (output valid, output chan);
  modport dst (input valid, input chan);
endinterface
`default_nettype wire

/* File: kvm_req_arbiter.sv */
// Selects the single active mechanism and qualifies its requests.
`timescale 1ns/1ns
`default_nettype none
module kvm_req_arbiter
  import kvm_sel_pkg::*;
#(
  parameter int CH_W = 2
) (
  // Clock and reset.
  input  wire logic            mclk_i,
  input  wire logic            rst_n_i,
  // Mechanism choice and the two synchronised request sources.
  input  wire logic            mech_sel,
  input  wire logic            btn_req,
  input  wire logic [CH_W-1:0] btn_chan,
  input  wire logic            rmt_req,
  input  wire logic [CH_W-1:0] rmt_chan,
  // Qualified request out.
  sel_req_if.src               req
);
  // Registered request state.
  typedef struct packed {
    logic            valid;
    logic [CH_W-1:0] chan;
  } arb_s;
  arb_s st;
  arb_s next_st;

  // Only the active mechanism passes; the other is dropped.
  always_comb begin
    next_st = '0;
    if (mech_sel == 1'b0) begin
      next_st.valid = btn_req;
      next_st.chan  = btn_chan;
    end else begin
      next_st.valid = rmt_req;
      next_st.chan  = rmt_chan;
    end
  end

  // Register the qualified request.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign req.valid = st.valid;
  assign req.chan  = st.chan;
endmodule
`default_nettype wire

/* File: kvm_sel_properties.sv */
// Assertions on the ports of the channel selection top.
`timescale 1ns/1ns
`default_nettype none
module kvm_sel_checker #(parameter int CH_W = 2, parameter int unsigned OFF_CYC = 8) (
  input wire logic            mclk_i, rst_n_i, btn_req_i, rmt_req_i, auth_emulated_i,
  input wire logic            kbd_is_kbd_i, mouse_is_mouse_i, admin_logout_i,
  input wire logic [CH_W-1:0] led_chan_o, kbd_route_o, mouse_route_o,
  input wire logic            kbd_en_o, mouse_en_o, auth_pwr_o, admin_role_o, filt_reject_o,
  input wire logic [7:0]      configurable_device_filtering_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  route_tied_a: assert property (kbd_route_o == mouse_route_o)
    else $error("keyboard and mouse routed apart");
  led_shows_a: assert property (led_chan_o == kbd_route_o)
    else $error("indicator differs from channel");
  off_on_chg_a: assert property ($changed(led_chan_o) && !auth_emulated_i |-> !auth_pwr_o)
    else $error("auth power kept on at switch");
  off_hold_a: assert property ($fell(auth_pwr_o) |-> !auth_pwr_o [*8])
    else $error("auth power back too soon");
  ident_en_a: assert property (kbd_en_o == (kbd_is_kbd_i && mouse_is_mouse_i) && mouse_en_o == kbd_en_o)
    else $error("enable without identity");
  flt_admin_a: assert property ($changed(configurable_device_filtering_o) |-> $past(admin_role_o))
    else $error("filter changed without admin");
  rej_pulse_a: assert property (filt_reject_o |-> !admin_role_o ##1 !filt_reject_o)
    else $error("bad reject pulse");
  role_out_a: assert property (admin_logout_i [*5] |-> !admin_role_o)
    else $error("admin role kept after logout");
  sel_src_a: assert property ($changed(led_chan_o) |-> $past(btn_req_i, 4) || $past(rmt_req_i, 4))
    else $error("channel changed without request");
  cover property ($fell(auth_pwr_o));
  cover property (filt_reject_o);
  cover property ($rose(admin_role_o));
endmodule
bind kvm_channel_select_auth_power kvm_sel_checker #(.CH_W(CH_W), .OFF_CYC(OFF_CYC)) i_chk (.*);
`default_nettype wire

/* File: kvm_sel_ctrl_model.sv */
// Model of the user selection controls: buttons, remote and keyboard shortcut.
`timescale 1ns/1ns
`default_nettype none
module kvm_sel_ctrl_model (
  input  wire logic  mclk_i,
  output logic       btn_req_o, rmt_req_o, hotkey_o,
  output logic [1:0] btn_chan_o, rmt_chan_o
);
  initial begin
    {btn_req_o, rmt_req_o, hotkey_o, btn_chan_o, rmt_chan_o} = '0;
  end
  // Source 0 is buttons, 1 remote, 2 shortcut; held eight cycles, then released.
  task automatic press(input int src, input logic [1:0] ch);
    @(negedge mclk_i);
    if (src == 0) btn_chan_o = ch;
    if (src == 1) rmt_chan_o = ch;
    btn_req_o = (src == 0);
    rmt_req_o = (src == 1);
    hotkey_o = (src == 2);
    repeat (8) @(negedge mclk_i);
    {btn_req_o, rmt_req_o, hotkey_o} = '0;
    // Released lines do not keep their last value.
    btn_chan_o = ~btn_chan_o;
    rmt_chan_o = ~rmt_chan_o;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the channel selection top.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       mclk_i = 0, rst_n_i = 0, mech = 0, emu = 0, kid = 1, mid = 1;
  logic       login = 0, logout = 0, fwr = 0, br, rr, hk, ke, me, pwr, adm, rej;
  logic [7:0] fdat = 8'hA5, flt;
  logic [1:0] bc, rc, led, kr, mr, ar;
  int         failures = 0, cmp_count = 0, cyc = 0;
  kvm_sel_ctrl_model i_ctl (.mclk_i(mclk_i), .btn_req_o(br), .rmt_req_o(rr),
    .hotkey_o(hk), .btn_chan_o(bc), .rmt_chan_o(rc));
  kvm_channel_select_auth_power #(.OFF_CYC(8)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .mech_remote_i(mech), .btn_req_i(br), .btn_chan_i(bc), .rmt_req_i(rr), .rmt_chan_i(rc),
    .kbd_hotkey_i(hk), .kbd_is_kbd_i(kid), .mouse_is_mouse_i(mid), .auth_emulated_i(emu),
    .admin_login_i(login), .admin_logout_i(logout), .filt_wr_i(fwr), .filt_data_i(fdat),
    .led_chan_o(led), .kbd_route_o(kr), .mouse_route_o(mr), .kbd_en_o(ke), .mouse_en_o(me),
    .auth_route_o(ar), .auth_pwr_o(pwr), .admin_role_o(adm),
    .configurable_device_filtering_o(flt), .filt_reject_o(rej));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One request; counts auth power-off cycles and checks the channel.
  task automatic t_req(input int src, input logic [1:0] ch, e, input int off);
    int n = 0;
    repeat (4) @(negedge mclk_i);
    fork i_ctl.press(src, ch); join_none
    repeat (24) @(negedge mclk_i) n += !pwr;
    chk("off_cycles", off[7:0], n[7:0]);
    chk("led", e, led);
    chk("kbd_route", e, kr);
    chk("mouse_route", e, mr);
    chk("auth_route", e, ar);
  endtask
  // One filter write; counts reject pulses.
  task automatic t_wr(input int er, input logic [7:0] ef);
    int n = 0;
    fwr = 1;
    repeat (8) @(negedge mclk_i) n += rej;
    fwr = 0;
    repeat (8) @(negedge mclk_i) n += rej;
    chk("rejects", er[7:0], n[7:0]);
    chk("filter", ef, flt);
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1;
    chk("led", 0, led);
    chk("pwr", 1, pwr);
    t_req(0, 2, 2, 8);
    t_req(0, 2, 2, 0);
    t_req(2, 1, 2, 0);
    t_req(1, 3, 2, 0);
    mech = 1;
    t_req(1, 3, 3, 8);
    t_req(0, 0, 3, 0);
    emu = 1;
    t_req(1, 1, 1, 0);
    kid = 0;
    #1 chk("kbd_en", 0, ke);
    mid = 0;
    #1 chk("mouse_en", 0, me);
    t_wr(1, 8'h00);
    login = 1;
    repeat (6) @(negedge mclk_i);
    chk("role", 1, adm);
    t_wr(0, 8'hA5);
    logout = 1;
    repeat (6) @(negedge mclk_i);
    chk("role", 0, adm);
    stop_test;
  end
endmodule
`default_nettype wire
